// ==== csf_pkg.sv ====
// Shared constants and types for the status-flag logic.
package csf_pkg;

  // Register-file address of the flag register.
  localparam logic [7:0] CSF_FLAG_ADDR = 8'hFC;

  // Bit positions in the flag register.
  localparam int CSF_BIT_CARRY = 7;
  localparam int CSF_BIT_ZERO  = 6;
  localparam int CSF_BIT_SIGN  = 5;
  localparam int CSF_BIT_OVFL  = 4;
  localparam int CSF_BIT_DEC   = 3;
  localparam int CSF_BIT_HALF  = 2;
  localparam int CSF_BIT_USR1  = 1;
  localparam int CSF_BIT_USR0  = 0;

  // Flag contents are indeterminate after reset; we pick zero.
  localparam logic [7:0] CSF_FLAG_RESET = 8'h00;

  // Operation classes presented by the execution datapath.
  typedef enum logic [2:0] {
    CSF_OP_NONE  = 3'b000,
    CSF_OP_ADD   = 3'b001,
    CSF_OP_SUB   = 3'b010,
    CSF_OP_LOGIC = 3'b011,
    CSF_OP_SHIFT = 3'b100
  } csf_op_t;

  // Jump condition codes; only C, V, Z, S are testable.
  typedef enum logic [3:0] {
    CSF_CC_NEVER = 4'h0,
    CSF_CC_ALWAYS = 4'h1,
    CSF_CC_C     = 4'h2,
    CSF_CC_NC    = 4'h3,
    CSF_CC_Z     = 4'h4,
    CSF_CC_NZ    = 4'h5,
    CSF_CC_S     = 4'h6,
    CSF_CC_NS    = 4'h7,
    CSF_CC_V     = 4'h8,
    CSF_CC_NV    = 4'h9
  } csf_cc_t;

endpackage : csf_pkg

// ==== csf_cond_eval.sv ====
// Conditional-jump evaluator over the testable flags.
`timescale 1ns/1ps
`default_nettype none
module csf_cond_eval
  import csf_pkg::*;
(
  // Flag contents.
  input  wire logic [7:0] flags,
  // Condition request.
  input  wire logic [3:0] cond,
  // Decision.
  output logic            taken
);

  // Only carry, zero, sign and overflow feed the decision; D, H and the
  // user bits are never looked at.
  always_comb begin
    case (cond)
      CSF_CC_NEVER:  taken = 1'b0;
      CSF_CC_ALWAYS: taken = 1'b1;
      CSF_CC_C:      taken = flags[CSF_BIT_CARRY];
      CSF_CC_NC:     taken = ~flags[CSF_BIT_CARRY];
      CSF_CC_Z:      taken = flags[CSF_BIT_ZERO];
      CSF_CC_NZ:     taken = ~flags[CSF_BIT_ZERO];
      CSF_CC_S:      taken = flags[CSF_BIT_SIGN];
      CSF_CC_NS:     taken = ~flags[CSF_BIT_SIGN];
      CSF_CC_V:      taken = flags[CSF_BIT_OVFL];
      CSF_CC_NV:     taken = ~flags[CSF_BIT_OVFL];
      default:       taken = 1'b0;
    endcase
  end

endmodule // csf_cond_eval
`default_nettype wire

// ==== csf_flags.sv ====
// Status-flag register with flag update and jump-condition output.
`timescale 1ns/1ps
`default_nettype none
module csf_flags
  import csf_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Operation result from the execution datapath.
  input  wire logic       op_valid,
  input  wire logic [2:0] op_class,
  input  wire logic [7:0] op_a,
  input  wire logic [7:0] op_b,
  input  wire logic [7:0] op_result,
  input  wire logic       op_carry,
  input  wire logic       op_half,
  input  wire logic       shift_out,
  input  wire logic [7:0] op_mask,
  // Register-file access.
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // Branch condition.
  input  wire logic [3:0] jump_cond,
  output logic            jump_taken,
  // Flag contents.
  output logic [7:0]      flags
);

  logic [7:0] next_flags;
  logic       ovf_add;
  logic       ovf_sub;
  logic       ovf_shift;
  logic       addr_hit;
  logic       op_live;

  // Every check in this module runs on the core clock and sleeps in reset.
  default clocking flag_cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Signed overflow: add operands of equal sign, or subtract operands of differing sign, giving a result whose sign differs from op_a.
  assign ovf_add   = (op_a[7] == op_b[7]) && (op_result[7] != op_a[7]);
  assign ovf_sub   = (op_a[7] != op_b[7]) && (op_result[7] != op_a[7]);
  // A shift overflows when the sign changes between operand and result.
  assign ovf_shift = op_a[7] ^ op_result[7];
  assign addr_hit  = (reg_addr == CSF_FLAG_ADDR);
  // An operation only lands when no flag write claims the same edge.
  assign op_live   = op_valid && !(reg_wr && addr_hit);

  // Zero detect, shared by every operation class that updates the flag.
  function automatic logic is_zero(input logic [7:0] value);
    return (value == 8'h00);
  endfunction

  // Next flag value. A register write is taken after the operation so
  // that software explicitly loading the flags has the last word.
  always_comb begin
    logic [7:0] upd;
    upd = flags;
    case (csf_op_t'(op_class))
      CSF_OP_ADD, CSF_OP_SUB: begin
        upd[CSF_BIT_CARRY] = op_carry;
        upd[CSF_BIT_ZERO]  = is_zero(op_result);
        upd[CSF_BIT_SIGN]  = op_result[7];
        upd[CSF_BIT_OVFL]  = (op_class == CSF_OP_ADD) ? ovf_add
                                                      : ovf_sub;
        upd[CSF_BIT_DEC]   = (op_class == CSF_OP_SUB);
        upd[CSF_BIT_HALF]  = op_half;
      end
      CSF_OP_LOGIC: begin
        upd[CSF_BIT_ZERO]  = is_zero(op_result);
        upd[CSF_BIT_SIGN]  = op_result[7];
        upd[CSF_BIT_OVFL]  = 1'b0;
      end
      CSF_OP_SHIFT: begin
        upd[CSF_BIT_CARRY] = shift_out;
        upd[CSF_BIT_ZERO]  = is_zero(op_result);
        upd[CSF_BIT_SIGN]  = op_result[7];
        upd[CSF_BIT_OVFL]  = ovf_shift;
      end
      default: upd = flags;
    endcase
    // Instruction-level mask leaves unaffected flags untouched; the user
    // bits are never touched by the arithmetic path.
    upd[CSF_BIT_USR1] = flags[CSF_BIT_USR1];
    upd[CSF_BIT_USR0] = flags[CSF_BIT_USR0];
    next_flags = flags;
    if (op_valid) begin
      next_flags = (upd & op_mask) | (flags & ~op_mask);
    end
    if (reg_wr && addr_hit) begin
      next_flags = reg_wdata;
    end
  end

  // Flag register; reset value is a fixed choice for determinism.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags <= CSF_FLAG_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // Reads return the live flags at the flag address, zero elsewhere.
  assign reg_rdata = addr_hit ? flags : 8'h00;

  // Branch decision sees only the testable flags.
  csf_cond_eval u_cond (
    .flags (flags),
    .cond  (jump_cond),
    .taken (jump_taken)
  );

  // Zero after a logical operation.
  property p_zero;
    (op_live && op_mask[CSF_BIT_ZERO] && op_class == CSF_OP_LOGIC)
    |=> flags[CSF_BIT_ZERO] == ($past(op_result) == 8'h00);
  endproperty
  zero_flag_a: assert property (p_zero)
    else $error("zero flag wrong");

  // Sign follows the result for every real class; codes past the shift
  // class are no operation at all and must leave the flag alone.
  property p_sign;
    (op_live && op_mask[CSF_BIT_SIGN] &&
     op_class inside {CSF_OP_ADD, CSF_OP_SUB, CSF_OP_LOGIC, CSF_OP_SHIFT})
    |=> flags[CSF_BIT_SIGN] == $past(op_result[7]);
  endproperty
  sign_flag_a: assert property (p_sign)
    else $error("sign flag wrong");

  // Carry takes the bit shifted out on shifts.
  property p_carry_shift;
    (op_live && op_mask[CSF_BIT_CARRY] && op_class == CSF_OP_SHIFT)
    |=> flags[CSF_BIT_CARRY] == $past(shift_out);
  endproperty
  carry_shift_a: assert property (p_carry_shift)
    else $error("carry on shift wrong");

  // Carry takes the carry out of bit 7 on additions.
  property p_carry_add;
    (op_live && op_mask[CSF_BIT_CARRY] && op_class == CSF_OP_ADD)
    |=> flags[CSF_BIT_CARRY] == $past(op_carry);
  endproperty
  carry_add_a: assert property (p_carry_add)
    else $error("carry on add wrong");

  // Logical operations clear overflow when op_mask selects the overflow bit.
  property p_ovf_logic;
    (op_live && op_mask[CSF_BIT_OVFL] && op_class == CSF_OP_LOGIC)
    |=> !flags[CSF_BIT_OVFL];
  endproperty
  ovf_logic_a: assert property (p_ovf_logic)
    else $error("overflow not cleared by logic op");

  // User bits move only on a direct write, whatever the mask says.
  property p_user_hold;
    !(reg_wr && addr_hit) |=> $stable(flags[CSF_BIT_USR1:CSF_BIT_USR0]);
  endproperty
  user_hold_a: assert property (p_user_hold)
    else $error("user bits changed without write");

  // With neither an operation nor a write, nothing moves.
  property p_hold_idle;
    (!op_valid && !(reg_wr && addr_hit)) |=> $stable(flags);
  endproperty
  hold_idle_a: assert property (p_hold_idle)
    else $error("flags changed while idle");

  // A direct write replaces the whole byte, even beside an operation.
  property p_direct_wr;
    (reg_wr && addr_hit) |=> flags == $past(reg_wdata);
  endproperty
  direct_wr_a: assert property (p_direct_wr)
    else $error("direct write not applied");

  // Decimal-adjust bit is set after a subtraction.
  property p_dec_sub;
    (op_live && op_mask[CSF_BIT_DEC] && op_class == CSF_OP_SUB)
    |=> flags[CSF_BIT_DEC];
  endproperty
  dec_flag_a: assert property (p_dec_sub)
    else $error("decimal flag not set after subtract");

  // Decimal-adjust bit is cleared after an addition.
  property p_dec_add;
    (op_live && op_mask[CSF_BIT_DEC] && op_class == CSF_OP_ADD)
    |=> !flags[CSF_BIT_DEC];
  endproperty
  dec_clear_a: assert property (p_dec_add)
    else $error("decimal flag not cleared after add");

  // Half carry records the nibble carry or borrow of the arithmetic.
  property p_half;
    (op_live && op_mask[CSF_BIT_HALF] &&
     op_class inside {CSF_OP_ADD, CSF_OP_SUB})
    |=> flags[CSF_BIT_HALF] == $past(op_half);
  endproperty
  half_flag_a: assert property (p_half)
    else $error("half carry flag wrong");

  // A carry condition jumps exactly when carry is set.
  property p_jump_c;
    (jump_cond == CSF_CC_C) |-> jump_taken == flags[CSF_BIT_CARRY];
  endproperty
  jump_c_a: assert property (p_jump_c)
    else $error("carry jump wrong");

  // Codes outside the defined set never jump.
  property p_jump_undef;
    (jump_cond > CSF_CC_NV) |-> !jump_taken;
  endproperty
  jump_dh_a: assert property (p_jump_undef)
    else $error("untestable condition taken");

  // The decision may not depend on the low four flag bits: if the
  // testable bits and the code hold still, so must the decision.
  property p_jump_low;
    ($stable(flags[CSF_BIT_CARRY:CSF_BIT_OVFL]) && $stable(jump_cond))
    |-> $stable(jump_taken);
  endproperty
  jump_lowbits_a: assert property (p_jump_low)
    else $error("jump decision follows an untestable bit");

  // Main scenarios.
  cov_add: cover property (op_valid && op_class == CSF_OP_ADD);
  cov_shift: cover property (op_valid && op_class == CSF_OP_SHIFT);
  cov_write: cover property (reg_wr && addr_hit);
  cov_jump: cover property (jump_taken && jump_cond == CSF_CC_Z);

endmodule // csf_flags
`default_nettype wire

// ==== csf_exec_model.sv ====
// Behavioural model of the execution datapath that feeds the flags.
`timescale 1ns/1ps
`default_nettype none
module csf_exec_model
  import csf_pkg::*;
(
  // Requested operation.
  input  wire logic [2:0] cls,
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  // Result presented to the flag logic.
  output logic [7:0]      result,
  output logic            carry,
  output logic            half,
  output logic            sh_out
);
  logic [8:0] sum;
  // Add, subtract, AND or shift left; the shift pushes bit 7 into carry.
  always_comb begin
    sum = {1'b0, a} + {1'b0, b};
    half = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
    if (cls == CSF_OP_SUB) begin
      sum = {1'b0, a} - {1'b0, b};
      half = a[3:0] < b[3:0];
    end
    if (cls == CSF_OP_LOGIC) sum = {1'b0, a & b};
    if (cls == CSF_OP_SHIFT) sum = {a, 1'b0};
    result = sum[7:0];
    carry = sum[8];
    sh_out = a[7];
  end
endmodule // csf_exec_model
`default_nettype wire

// ==== tb_csf_flags.sv ====
// Self-checking testbench for the status-flag register.
`timescale 1ns/1ps
`default_nettype none
module tb_csf_flags;
  import csf_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       op_valid = 1'b0;
  logic [2:0] op_class = 3'h0;
  logic [7:0] op_a = 8'h00;
  logic [7:0] op_b = 8'h00;
  logic [7:0] op_mask = 8'h00;
  logic       reg_wr = 1'b0;
  logic [7:0] reg_addr = CSF_FLAG_ADDR;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] jump_cond = 4'h0;
  logic [7:0] op_result, reg_rdata, flags;
  logic       op_carry, op_half, shift_out, jump_taken;
  int         failures = 0;
  int         checked = 0;
  logic [7:0] rdata;

  csf_exec_model PART (.cls(op_class), .a(op_a), .b(op_b),
    .result(op_result), .carry(op_carry), .half(op_half),
    .sh_out(shift_out));
  csf_flags DUT (.sys_clk(sys_clk), .rst(rst), .op_valid(op_valid),
    .op_class(op_class), .op_a(op_a), .op_b(op_b), .op_result(op_result),
    .op_carry(op_carry), .op_half(op_half), .shift_out(shift_out),
    .op_mask(op_mask), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .jump_cond(jump_cond),
    .jump_taken(jump_taken), .flags(flags));

  // A 100 ns clock.
  always #50 sys_clk = ~sys_clk;

  // Compares one byte result and counts it.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One register-file write, held for exactly one edge.
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk) #1;
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(posedge sys_clk) #1;
    reg_wr = 1'b0;
    reg_addr = CSF_FLAG_ADDR;
  endtask

  // One register-file read; the data is taken mid-cycle, once settled.
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk) #1;
    reg_addr = addr;
    @(negedge sys_clk);
    data = reg_rdata;
    @(posedge sys_clk) #1;
    reg_addr = CSF_FLAG_ADDR;
  endtask

  // One operation; operands stay put so the model keeps its result.
  task automatic op(input csf_op_t c, input logic [7:0] a, b, m);
    @(posedge sys_clk) #1;
    op_valid = 1'b1;
    op_class = c;
    op_a = a;
    op_b = b;
    op_mask = m;
    @(posedge sys_clk) #1;
    op_valid = 1'b0;
  endtask

  // Sweeps every condition code; bit n of taken_set says if code n jumps.
  task automatic jumps(input logic [15:0] taken_set);
    for (int c = 0; c < 16; c++) begin
      @(posedge sys_clk) #1;
      jump_cond = c[3:0];
      #1 chk({7'h00, jump_taken}, {7'h00, taken_set[c]});
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence; expected bytes are worked out by hand from the rules.
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
    rd(CSF_FLAG_ADDR, rdata);
    chk(rdata, CSF_FLAG_RESET);
    wr(CSF_FLAG_ADDR, 8'h5A);
    chk(flags, 8'h5A);
    rd(CSF_FLAG_ADDR, rdata);
    chk(rdata, 8'h5A);
    wr(8'hFD, 8'h00);
    chk(flags, 8'h5A);
    rd(8'hFD, rdata);
    chk(rdata, 8'h00);
    wr(CSF_FLAG_ADDR, 8'h03);
    op(CSF_OP_ADD, 8'h80, 8'h80, 8'hFC);
    chk(flags, 8'hD3);
    op(CSF_OP_SUB, 8'h10, 8'h01, 8'hFF);
    chk(flags, 8'h0F);
    op(CSF_OP_LOGIC, 8'hF0, 8'hC0, 8'h70);
    chk(flags, 8'h2F);
    op(CSF_OP_SHIFT, 8'h81, 8'h00, 8'hF0);
    chk(flags, 8'h9F);
    op(CSF_OP_NONE, 8'h00, 8'h00, 8'hFF);
    chk(flags, 8'h9F);
    wr(CSF_FLAG_ADDR, 8'h0F);
    jumps(16'h02AA);
    wr(CSF_FLAG_ADDR, 8'hF0);
    jumps(16'h0156);
    final_report();
  end

  // The tests need about 70 cycles; this cuts a hang well beyond that.
  initial begin
    #50000;
    failures++;
    final_report();
  end
endmodule // tb_csf_flags
`default_nettype wire
